// ### core/imtc_top.sv
// two-wire bus master transmit controller with slave address detection
`timescale 1ns/10ps
module imtc_top #(
	parameter int QUARTER = imtc_pkg::QUARTER_CYC // cycles per quarter bit at rate 0
)(
	input  wire logic        hclk,      // bus clock
	input  wire logic        hresetn,   // async reset, low
	input  wire logic        hsel,      // slave select
	input  wire logic [31:0] haddr,     // address
	input  wire logic [1:0]  htrans,    // transfer type
	input  wire logic        hwrite,    // write strobe
	input  wire logic [2:0]  hsize,     // transfer size
	input  wire logic [31:0] hwdata,    // write data
	input  wire logic        hready,    // bus ready
	output logic             hreadyout, // slave ready
	output logic [31:0]      hrdata,    // read data
	output logic             hresp,     // response
	input  wire logic        scl_in,    // clock line level
	output logic             scl_out,   // clock line drive level
	output logic             scl_oe,    // clock line pulled low
	input  wire logic        sda_in,    // data line level
	output logic             sda_out,   // data line drive level
	output logic             sda_oe,    // data line pulled low
	output logic             irq        // interrupt level
);
	localparam logic [7:0] QMAX = 8'(QUARTER - 1);

	imtc_pkg::imtc_ctrl_s  ctrl_reg;
	imtc_pkg::imtc_ctrl_s  wctl;
	imtc_pkg::imtc_state_e st_reg;
	imtc_pkg::imtc_slv_e   slv_reg;
	logic [7:0]            status_reg;
	logic [7:0]            data_reg;
	logic [7:0]            own_reg;
	logic [7:0]            wa_reg;
	logic [7:0]            rd_next;
	logic [31:0]           hrdata_reg;
	logic [7:0]            div_reg;
	logic [7:0]            sh_reg;
	logic [7:0]            s_sh_reg;
	logic [7:0]            m_code_reg;
	logic [7:0]            s_code_reg;
	logic [2:0]            irq_st_reg;
	logic [2:0]            irq_mask_reg;
	logic [2:0]            irq_ev;
	logic [2:0]            scl_sy_reg;
	logic [2:0]            sda_sy_reg;
	logic [1:0]            ph_reg;
	logic [3:0]            bit_reg;
	logic [3:0]            s_cnt_reg;
	logic                  wr_reg;
	logic                  hready_reg;
	logic                  hresp_reg;
	logic                  irq_reg;
	logic                  scl_f_reg;
	logic                  sda_f_reg;
	logic                  scl_d_reg;
	logic                  sda_d_reg;
	logic                  busy_reg;
	logic                  rd_reg;
	logic                  abyte_reg;
	logic                  rep_reg;
	logic                  ack_reg;
	logic                  arb_reg;
	logic                  arb_ev_reg;
	logic                  m_scl_reg;
	logic                  m_sda_reg;
	logic                  m_ev_reg;
	logic                  stop_clr_reg;
	logic                  s_on_reg;
	logic                  s_scl_reg;
	logic                  s_sda_reg;
	logic                  s_ev_reg;
	logic                  scl_oe_reg;
	logic                  sda_oe_reg;
	logic                  zero_reg;

	wire acc      = hsel & htrans[1] & hready;
	wire w_ctrl   = wr_reg && wa_reg == imtc_pkg::OFF_CTRL;
	wire tick     = div_reg == 8'h00;
	wire scl_rise = scl_f_reg & ~scl_d_reg;
	wire start_det = scl_f_reg & scl_d_reg & sda_d_reg & ~sda_f_reg;
	wire stop_det = scl_f_reg & scl_d_reg & ~sda_d_reg & sda_f_reg;
	wire gc_hit   = s_sh_reg[7:1] == 7'h00;
	assign wctl = imtc_pkg::imtc_ctrl_s'(hwdata[7:0]);

	assign hreadyout = hready_reg;
	assign hrdata    = hrdata_reg;
	assign hresp     = hresp_reg;
	assign irq       = irq_reg;
	assign scl_oe    = scl_oe_reg;
	assign sda_oe    = sda_oe_reg;
	assign scl_out   = zero_reg;
	assign sda_out   = zero_reg;

	// read mux, sampled in the address phase
	always_comb
	begin
		rd_next = 8'h00;
		if (haddr[7:0] == imtc_pkg::OFF_CTRL)
			rd_next = ctrl_reg;
		else if (haddr[7:0] == imtc_pkg::OFF_STAT)
			rd_next = status_reg & imtc_pkg::ST_MASK;
		else if (haddr[7:0] == imtc_pkg::OFF_DATA)
			rd_next = data_reg;
		else if (haddr[7:0] == imtc_pkg::OFF_OWN)
			rd_next = own_reg;
		else if (haddr[7:0] == imtc_pkg::OFF_IRQ_ST)
			rd_next = {5'h00, irq_st_reg};
		else if (haddr[7:0] == imtc_pkg::OFF_IRQ_MSK)
			rd_next = {5'h00, irq_mask_reg};
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_reg     <= 1'b0;
			wa_reg     <= 8'h00;
			hrdata_reg <= 32'h00000000;
			hready_reg <= 1'b1;
			hresp_reg  <= 1'b0;
			zero_reg   <= 1'b0;
		end
		else
		begin
			wr_reg <= acc & hwrite;
			if (acc)
				wa_reg <= haddr[7:0];
			if (acc && !hwrite)
				hrdata_reg <= {24'h000000, rd_next};
		end
	end

	// software registers besides control
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			data_reg     <= imtc_pkg::DATA_RST;
			own_reg      <= imtc_pkg::OWN_RST;
			irq_mask_reg <= imtc_pkg::IRQ_RST;
		end
		else if (wr_reg)
		begin
			if (wa_reg == imtc_pkg::OFF_DATA)
				data_reg <= hwdata[7:0];
			else if (wa_reg == imtc_pkg::OFF_OWN)
				own_reg <= hwdata[7:0];
			else if (wa_reg == imtc_pkg::OFF_IRQ_MSK)
				irq_mask_reg <= hwdata[2:0];
		end
	end

	// control: flag only cleared by software, hardware set wins
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			ctrl_reg <= imtc_pkg::CTRL_RST;
		else
		begin
			if (w_ctrl)
			begin
				ctrl_reg      <= wctl;
				ctrl_reg.flag <= ctrl_reg.flag & wctl.flag;
			end
			if (stop_clr_reg)
				ctrl_reg.stop <= 1'b0;
			if (m_ev_reg || s_ev_reg)
				ctrl_reg.flag <= 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			status_reg <= imtc_pkg::ST_IDLE;
		else if (s_ev_reg)
			status_reg <= s_code_reg;
		else if (m_ev_reg)
			status_reg <= m_code_reg;
		else if (stop_clr_reg && !ctrl_reg.start)
			status_reg <= imtc_pkg::ST_IDLE;
	end

	always_comb
	begin
		irq_ev = 3'h0;
		irq_ev[imtc_pkg::IRQ_FLAG] = m_ev_reg | s_ev_reg;
		irq_ev[imtc_pkg::IRQ_ADDR] = s_ev_reg;
		irq_ev[imtc_pkg::IRQ_ARB]  = arb_ev_reg;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			irq_st_reg <= imtc_pkg::IRQ_RST;
			irq_reg    <= 1'b0;
		end
		else
		begin
			if (wr_reg && wa_reg == imtc_pkg::OFF_IRQ_ST)
				irq_st_reg <= (irq_st_reg & ~hwdata[2:0]) | irq_ev;
			else
				irq_st_reg <= irq_st_reg | irq_ev;
			irq_reg <= |(irq_st_reg & irq_mask_reg);
		end
	end

	// line sampling: a level counts once stages two and three agree
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			scl_sy_reg <= 3'h7;
			sda_sy_reg <= 3'h7;
			scl_f_reg  <= 1'b1;
			sda_f_reg  <= 1'b1;
			scl_d_reg  <= 1'b1;
			sda_d_reg  <= 1'b1;
		end
		else
		begin
			scl_sy_reg <= {scl_sy_reg[1:0], scl_in};
			sda_sy_reg <= {sda_sy_reg[1:0], sda_in};
			if (scl_sy_reg[1] == scl_sy_reg[2])
				scl_f_reg <= scl_sy_reg[2];
			if (sda_sy_reg[1] == sda_sy_reg[2])
				sda_f_reg <= sda_sy_reg[2];
			scl_d_reg <= scl_f_reg;
			sda_d_reg <= sda_f_reg;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			busy_reg <= 1'b0;
			div_reg  <= 8'h00;
		end
		else
		begin
			if (!ctrl_reg.enable || stop_det)
				busy_reg <= 1'b0;
			else if (start_det)
				busy_reg <= 1'b1;
			div_reg <= tick ? (QMAX >> ctrl_reg.rate) : div_reg - 8'h01;
		end
	end

	// master engine, four quarter-bit phases per step
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			st_reg       <= imtc_pkg::M_IDLE;
			ph_reg       <= 2'h0;
			bit_reg      <= 4'h0;
			sh_reg       <= 8'h00;
			rd_reg       <= 1'b0;
			abyte_reg    <= 1'b0;
			rep_reg      <= 1'b0;
			ack_reg      <= 1'b0;
			arb_reg      <= 1'b0;
			arb_ev_reg   <= 1'b0;
			m_scl_reg    <= 1'b0;
			m_sda_reg    <= 1'b0;
			m_ev_reg     <= 1'b0;
			m_code_reg   <= imtc_pkg::ST_IDLE;
			stop_clr_reg <= 1'b0;
		end
		else
		begin
			m_ev_reg     <= 1'b0;
			arb_ev_reg   <= 1'b0;
			stop_clr_reg <= 1'b0;
			if (!ctrl_reg.enable)
			begin
				st_reg    <= imtc_pkg::M_IDLE;
				m_scl_reg <= 1'b0;
				m_sda_reg <= 1'b0;
				ph_reg    <= 2'h0;
			end
			else
				case (st_reg)
				imtc_pkg::M_IDLE:
					if (ctrl_reg.start && !ctrl_reg.flag && !busy_reg && slv_reg == imtc_pkg::S_IDLE)
					begin
						st_reg  <= imtc_pkg::M_START;
						ph_reg  <= 2'h0;
						rep_reg <= 1'b0;
					end
				imtc_pkg::M_START:
					if (tick && (ph_reg != 2'h2 || (scl_f_reg && sda_f_reg)))
					begin
						ph_reg <= ph_reg + 2'h1;
						case (ph_reg)
						2'h0: m_sda_reg <= 1'b0;
						2'h1: m_scl_reg <= 1'b0;
						2'h2: m_sda_reg <= 1'b1;
						default:
						begin
							m_scl_reg  <= 1'b1;
							arb_reg    <= 1'b0;
							abyte_reg  <= 1'b1;
							m_ev_reg   <= 1'b1;
							m_code_reg <= rep_reg ? imtc_pkg::ST_RESTART : imtc_pkg::ST_START;
							st_reg     <= imtc_pkg::M_HOLD;
						end
						endcase
					end
				imtc_pkg::M_HOLD:
					if (!ctrl_reg.flag && !m_ev_reg)
					begin
						ph_reg <= 2'h0;
						if (ctrl_reg.stop)
							st_reg <= imtc_pkg::M_STOP;
						else if (ctrl_reg.start)
						begin
							st_reg  <= imtc_pkg::M_START;
							rep_reg <= 1'b1;
						end
						else
						begin
							st_reg  <= imtc_pkg::M_BIT;
							sh_reg  <= data_reg;
							rd_reg  <= data_reg[0];
							bit_reg <= 4'h0;
						end
					end
				imtc_pkg::M_BIT:
					if (tick && (ph_reg != 2'h2 || scl_f_reg))
					begin
						ph_reg <= ph_reg + 2'h1;
						case (ph_reg)
						2'h0: m_sda_reg <= bit_reg != 4'h8 && !sh_reg[7];
						2'h1: m_scl_reg <= 1'b0;
						2'h2:
							if (bit_reg == 4'h8)
								ack_reg <= !sda_f_reg;
							else if (sh_reg[7] && !sda_f_reg)
							begin
								st_reg     <= imtc_pkg::M_IDLE;
								arb_reg    <= 1'b1;
								arb_ev_reg <= 1'b1;
								m_ev_reg   <= 1'b1;
								m_code_reg <= imtc_pkg::ST_ARB;
							end
						default:
						begin
							m_scl_reg <= 1'b1;
							if (bit_reg == 4'h8)
							begin
								st_reg    <= imtc_pkg::M_HOLD;
								abyte_reg <= 1'b0;
								m_ev_reg  <= 1'b1;
								if (!abyte_reg)
									m_code_reg <= ack_reg ? imtc_pkg::ST_D_ACK : imtc_pkg::ST_D_NACK;
								else if (rd_reg)
									m_code_reg <= ack_reg ? imtc_pkg::ST_AR_ACK : imtc_pkg::ST_AR_NACK;
								else
									m_code_reg <= ack_reg ? imtc_pkg::ST_AW_ACK : imtc_pkg::ST_AW_NACK;
							end
							else
							begin
								sh_reg  <= {sh_reg[6:0], 1'b0};
								bit_reg <= bit_reg + 4'h1;
							end
						end
						endcase
					end
				default:
					if (tick && (ph_reg != 2'h2 || scl_f_reg))
					begin
						ph_reg <= ph_reg + 2'h1;
						case (ph_reg)
						2'h0: m_sda_reg <= 1'b1;
						2'h1: m_scl_reg <= 1'b0;
						2'h2: m_sda_reg <= 1'b0;
						default:
						begin
							stop_clr_reg <= 1'b1;
							st_reg       <= imtc_pkg::M_IDLE;
						end
						endcase
					end
				endcase
		end
	end

	// slave address watcher, runs on every transfer on the bus while enable is set
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			slv_reg    <= imtc_pkg::S_IDLE;
			s_cnt_reg  <= 4'h0;
			s_sh_reg   <= 8'h00;
			s_on_reg   <= 1'b0;
			s_scl_reg  <= 1'b0;
			s_sda_reg  <= 1'b0;
			s_ev_reg   <= 1'b0;
			s_code_reg <= imtc_pkg::ST_IDLE;
		end
		else if (!ctrl_reg.enable)
		begin
			slv_reg   <= imtc_pkg::S_IDLE;
			s_on_reg  <= 1'b0;
			s_scl_reg <= 1'b0;
			s_sda_reg <= 1'b0;
			s_ev_reg  <= 1'b0;
		end
		else
		begin
			s_ev_reg <= 1'b0;
			if (start_det)
			begin
				s_cnt_reg <= 4'h0;
				s_on_reg  <= 1'b1;
			end
			else if (scl_rise && s_on_reg && s_cnt_reg != 4'h8)
			begin
				s_sh_reg  <= {s_sh_reg[6:0], sda_f_reg};
				s_cnt_reg <= s_cnt_reg + 4'h1;
			end
			else if (s_on_reg && s_cnt_reg == 4'h8)
			begin
				s_on_reg <= 1'b0;
				if (st_reg == imtc_pkg::M_IDLE && ctrl_reg.ack &&
					(s_sh_reg[7:1] == own_reg[7:1] || (gc_hit && own_reg[0])))
					slv_reg <= imtc_pkg::S_ACK;
			end
			case (slv_reg)
			imtc_pkg::S_ACK:
				if (!scl_f_reg)
				begin
					s_sda_reg <= 1'b1;
					slv_reg   <= imtc_pkg::S_BIT9;
				end
			imtc_pkg::S_BIT9:
				if (scl_d_reg && !scl_f_reg)
				begin
					s_sda_reg <= 1'b0;
					s_scl_reg <= 1'b1;
					s_ev_reg  <= 1'b1;
					slv_reg   <= imtc_pkg::S_HOLD;
					if (s_sh_reg[0])
						s_code_reg <= arb_reg ? imtc_pkg::ST_SLV_ARB_R : imtc_pkg::ST_SLV_R;
					else if (gc_hit)
						s_code_reg <= arb_reg ? imtc_pkg::ST_GC_ARB : imtc_pkg::ST_GC;
					else
						s_code_reg <= arb_reg ? imtc_pkg::ST_SLV_ARB_W : imtc_pkg::ST_SLV_W;
				end
			imtc_pkg::S_HOLD:
				if (!ctrl_reg.flag && !s_ev_reg)
				begin
					s_scl_reg <= 1'b0;
					slv_reg   <= imtc_pkg::S_IDLE;
				end
			default:
				s_scl_reg <= 1'b0;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			scl_oe_reg <= 1'b0;
			sda_oe_reg <= 1'b0;
		end
		else
		begin
			scl_oe_reg <= m_scl_reg | s_scl_reg;
			sda_oe_reg <= m_sda_reg | s_sda_reg;
		end
	end

	hold_clock_a: assert property (@(posedge hclk) disable iff (!hresetn)
		st_reg == imtc_pkg::M_HOLD && $past(st_reg) == imtc_pkg::M_HOLD |-> scl_oe_reg)
		else $error("clock line not held while waiting");
	status_stable_a: assert property (@(posedge hclk) disable iff (!hresetn)
		ctrl_reg.flag && !m_ev_reg && !s_ev_reg |=> $stable(status_reg))
		else $error("status moved while flag set");
	start_free_a: assert property (@(posedge hclk) disable iff (!hresetn)
		st_reg == imtc_pkg::M_START && $past(st_reg) == imtc_pkg::M_IDLE |-> !$past(busy_reg))
		else $error("start began on a busy bus");
	stop_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
		stop_clr_reg && !w_ctrl |=> !ctrl_reg.stop)
		else $error("stop request not cleared");
	arb_release_a: assert property (@(posedge hclk) disable iff (!hresetn)
		arb_ev_reg |-> st_reg == imtc_pkg::M_IDLE && !m_scl_reg && !m_sda_reg && m_code_reg == imtc_pkg::ST_ARB)
		else $error("arbitration loss did not release");
	master_status_a: assert property (@(posedge hclk) disable iff (!hresetn)
		m_ev_reg && !s_ev_reg |=> status_reg == $past(m_code_reg) && ctrl_reg.flag)
		else $error("status or flag missing after event");
	addr_match_a: assert property (@(posedge hclk) disable iff (!hresetn)
		s_ev_reg |=> ctrl_reg.flag && irq_st_reg[imtc_pkg::IRQ_ADDR])
		else $error("address match not flagged");
	quiet_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!ctrl_reg.enable [*3] |-> !scl_oe_reg && !sda_oe_reg)
		else $error("disabled interface drives a line");
endmodule

// ### core/imtc_pkg.sv
// constants and types for the two-wire master transmit controller
package imtc_pkg;
	localparam logic [7:0] OFF_CTRL     = 8'h00;
	localparam logic [7:0] OFF_STAT     = 8'h04;
	localparam logic [7:0] OFF_DATA     = 8'h08;
	localparam logic [7:0] OFF_OWN      = 8'h0c;
	localparam logic [7:0] OFF_IRQ_ST   = 8'h10;
	localparam logic [7:0] OFF_IRQ_MSK  = 8'h14;
	localparam logic [7:0] ST_START     = 8'h08;
	localparam logic [7:0] ST_RESTART   = 8'h10;
	localparam logic [7:0] ST_AW_ACK    = 8'h18;
	localparam logic [7:0] ST_AW_NACK   = 8'h20;
	localparam logic [7:0] ST_D_ACK     = 8'h28;
	localparam logic [7:0] ST_D_NACK    = 8'h30;
	localparam logic [7:0] ST_ARB       = 8'h38;
	localparam logic [7:0] ST_AR_ACK    = 8'h40;
	localparam logic [7:0] ST_AR_NACK   = 8'h48;
	localparam logic [7:0] ST_SLV_W     = 8'h60;
	localparam logic [7:0] ST_SLV_ARB_W = 8'h68;
	localparam logic [7:0] ST_GC        = 8'h70;
	localparam logic [7:0] ST_GC_ARB    = 8'h78;
	localparam logic [7:0] ST_SLV_R     = 8'ha8;
	localparam logic [7:0] ST_SLV_ARB_R = 8'hb0;
	localparam logic [7:0] ST_IDLE      = 8'hf8;
	localparam logic [7:0] ST_MASK      = 8'hf8;
	localparam logic [7:0] CTRL_RST     = 8'h00;
	localparam logic [7:0] DATA_RST     = 8'h00;
	localparam logic [7:0] OWN_RST      = 8'h00;
	localparam logic [2:0] IRQ_RST      = 3'h0;
	localparam int         IRQ_FLAG     = 0;
	localparam int         IRQ_ADDR     = 1;
	localparam int         IRQ_ARB      = 2;
	localparam int         CLK_PERIOD_NS = 50;
	localparam int         BIT_TIME_NS  = 10000;
	localparam int         QUARTER_CYC  = BIT_TIME_NS / (4 * CLK_PERIOD_NS);

	typedef struct packed {
		logic       rate2;
		logic       enable;
		logic       start;
		logic       stop;
		logic       flag;
		logic       ack;
		logic [1:0] rate;
	} imtc_ctrl_s;

	typedef enum logic [2:0] {
		M_IDLE  = 3'b000,
		M_START = 3'b001,
		M_BIT   = 3'b010,
		M_STOP  = 3'b011,
		M_HOLD  = 3'b100
	} imtc_state_e;

	typedef enum logic [1:0] {
		S_IDLE = 2'b00,
		S_ACK  = 2'b01,
		S_BIT9 = 2'b10,
		S_HOLD = 2'b11
	} imtc_slv_e;
endpackage

// ### tb/imtc_slave_model.sv
// behavioural two-wire slave answering the controller under test
`timescale 1ns/10ps
module imtc_slave_model #(
	parameter logic [6:0] ADDR = 7'h3a // slave address
)(
	input  wire logic  scl,      // clock wire level
	input  wire logic  sda,      // data wire level
	input  wire logic  nack,     // refuse data bytes
	input  wire logic [31:0] stretch, // clock stretch after ack, ns
	output logic       sda_oe,   // pulls data low
	output logic       scl_oe,   // pulls clock low
	output logic [7:0] rx_byte,  // last byte acknowledged
	output int         rx_count  // bytes acknowledged
);
	int         bits;
	logic [7:0] sh;
	logic       sel;
	logic       first;
	logic       ack_drv;
	initial
	begin
		sda_oe = 1'b0;
		scl_oe = 1'b0;
		rx_byte = 8'h00;
		rx_count = 0;
		bits = 0;
		sh = 8'h00;
		sel = 1'b0;
		first = 1'b0;
		ack_drv = 1'b0;
	end
	// start or repeated start
	always @(negedge sda)
		if (scl === 1'b1)
		begin
			bits = 0;
			first = 1'b1;
			sel = 1'b0;
		end
	// stop
	always @(posedge sda)
		if (scl === 1'b1)
			sel = 1'b0;
	always @(posedge scl)
		if (bits == 8)
			bits = 0;
		else
		begin
			sh = {sh[6:0], sda};
			bits++;
		end
	always @(negedge scl)
		if (bits == 8)
		begin
			if (first)
				sel = (sh[7:1] == ADDR);
			ack_drv = sel && (first || !nack);
			first = 1'b0;
			if (ack_drv)
			begin
				rx_byte = sh;
				rx_count++;
			end
			#20 sda_oe = ack_drv;
		end
		else if (ack_drv)
		begin
			#20 sda_oe = 1'b0;
			ack_drv = 1'b0;
			scl_oe = 1'b1;
			#(stretch) scl_oe = 1'b0;
		end
endmodule

// ### tb/imtc_top_test.sv
// self-checking bench for the two-wire master transmit controller
`timescale 1ns/10ps
module imtc_top_test;
	localparam logic [7:0] EN = 8'h40;
	localparam logic [7:0] GO = 8'h20;
	localparam logic [7:0] STP = 8'h10;
	localparam logic [7:0] AAK = 8'h04;
	localparam logic [7:0] SLV = 8'h74;
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic        hwrite;
	logic [31:0] haddr;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic [31:0] rd;
	logic [31:0] seed;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic        hreadyout;
	logic        hresp;
	logic        scl_out;
	logic        scl_oe;
	logic        sda_out;
	logic        sda_oe;
	logic        irq;
	logic        m_scl_low;
	logic        m_sda_low;
	logic        steal;
	logic        nack;
	logic        p_sda_oe;
	logic        p_scl_oe;
	logic        ack_bit;
	logic [7:0]  own;
	logic [7:0]  rx_byte;
	logic [7:0]  exp_q[$];
	int          rx_count;
	int          stretch;
	int          n_mismatch;
	int          check_count;
	wire scl_w = !(scl_oe | p_scl_oe | m_scl_low);
	wire sda_w = !(sda_oe | p_sda_oe | m_sda_low | steal);

	imtc_top #(.QUARTER(4)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .scl_in(scl_w), .scl_out(scl_out),
		.scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));
	imtc_slave_model #(.ADDR(SLV[7:1])) partner_u (.scl(scl_w), .sda(sda_w), .nack(nack),
		.stretch(stretch), .sda_oe(p_sda_oe), .scl_oe(p_scl_oe), .rx_byte(rx_byte), .rx_count(rx_count));

	initial
		hclk = 1'b0;
	always #25 hclk = ~hclk;

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("BAD %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h0, a};
		hwrite <= w;
		hsize <= 3'b010;
		@(posedge hclk);
		while (hreadyout !== 1'b1)
			@(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1)
			@(posedge hclk);
		rd = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus(1'b1, a, {24'h0, d});
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		bus(1'b0, a, 32'h0);
		check(rd, {24'h0, e});
	endtask
	task automatic wf(input logic [7:0] e);
		for (int i = 0; i < 4000 && irq !== 1'b1; i++)
			@(posedge hclk);
		wr(imtc_pkg::OFF_IRQ_ST, 8'h01);
		rdc(imtc_pkg::OFF_STAT, e);
		check(32'(irq), 32'h0);
	endtask
	task automatic send(input logic [7:0] b, input logic [7:0] c, input logic [7:0] e);
		wr(imtc_pkg::OFF_DATA, b);
		wr(imtc_pkg::OFF_CTRL, c);
		wf(e);
		if (e == imtc_pkg::ST_AW_ACK || e == imtc_pkg::ST_D_ACK || e == imtc_pkg::ST_AR_ACK)
		begin
			exp_q.push_back(b);
			check(32'(rx_byte), 32'(b));
		end
		check(32'(rx_count), 32'(exp_q.size()));
	endtask
	task automatic stop_wait();
		wr(imtc_pkg::OFF_CTRL, EN | STP);
		for (int i = 0; i < 100; i++)
		begin
			bus(1'b0, imtc_pkg::OFF_CTRL, 32'h0);
			if (rd[4] === 1'b0)
				break;
		end
	endtask
	task automatic bb_byte(input logic [7:0] b);
		logic [8:0] b9;
		b9 = {b, 1'b1};
		m_sda_low <= 1'b1;
		#200 m_scl_low <= 1'b1;
		for (int i = 8; i >= 0; i--)
		begin
			#100 m_sda_low <= !b9[i];
			#100 m_scl_low <= 1'b0;
			#200 ack_bit = sda_w;
			m_scl_low <= 1'b1;
		end
		// let the synchronised clock fall reach the flag and irq
		#600;
	endtask
	task automatic bb_stop();
		#100 m_sda_low <= 1'b1;
		#100 m_scl_low <= 1'b0;
		for (int i = 0; i < 400 && scl_w !== 1'b1; i++)
			#50;
		#200 m_sda_low <= 1'b0;
		#400;
	endtask

	initial
	begin
		#2000000;
		n_mismatch++;
		summarize();
	end
	initial
	begin
		{hsel, hwrite, haddr, hwdata, htrans, hsize} = '0;
		{m_scl_low, m_sda_low, steal, nack, hresetn} = '0;
		stretch = 0;
		n_mismatch = 0;
		check_count = 0;
		seed = 32'h9d0b77b8;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		rdc(imtc_pkg::OFF_CTRL, imtc_pkg::CTRL_RST);
		rdc(imtc_pkg::OFF_STAT, imtc_pkg::ST_IDLE);
		rdc(imtc_pkg::OFF_DATA, imtc_pkg::DATA_RST);
		rdc(imtc_pkg::OFF_OWN, imtc_pkg::OWN_RST);
		rdc(imtc_pkg::OFF_IRQ_ST, {5'h0, imtc_pkg::IRQ_RST});
		rdc(imtc_pkg::OFF_IRQ_MSK, 8'h00);
		rdc(8'h18, 8'h00);
		check(32'({hresp, scl_out, sda_out}), 32'h0);
		own = 8'(rnd());
		own = {1'b1, own[5:0], 1'b1};
		wr(imtc_pkg::OFF_OWN, own);
		rdc(imtc_pkg::OFF_OWN, own);
		$display("test registers done");
		wr(imtc_pkg::OFF_CTRL, AAK);
		bb_byte({own[7:1], 1'b0});
		check(32'(ack_bit), 32'h1);
		bb_stop();
		rdc(imtc_pkg::OFF_STAT, imtc_pkg::ST_IDLE);
		wr(imtc_pkg::OFF_IRQ_MSK, 8'h02);
		wr(imtc_pkg::OFF_CTRL, EN | AAK);
		bb_byte({own[7:1], 1'b0});
		check(32'(ack_bit), 32'h0);
		check(32'(irq), 32'h1);
		rdc(imtc_pkg::OFF_STAT, imtc_pkg::ST_SLV_W);
		wr(imtc_pkg::OFF_IRQ_ST, 8'h03);
		wr(imtc_pkg::OFF_CTRL, EN | AAK);
		check(32'(irq), 32'h0);
		bb_stop();
		wr(imtc_pkg::OFF_IRQ_MSK, 8'h00);
		bb_byte(8'h00);
		check(32'(ack_bit), 32'h0);
		rdc(imtc_pkg::OFF_STAT, imtc_pkg::ST_GC);
		rdc(imtc_pkg::OFF_IRQ_ST, 8'h03);
		check(32'(irq), 32'h0);
		wr(imtc_pkg::OFF_IRQ_ST, 8'h03);
		wr(imtc_pkg::OFF_CTRL, EN | AAK);
		bb_stop();
		$display("test slave done");
		wr(imtc_pkg::OFF_IRQ_MSK, 8'h01);
		wr(imtc_pkg::OFF_CTRL, EN | GO);
		wf(imtc_pkg::ST_START);
		send(SLV, EN, imtc_pkg::ST_AW_ACK);
		repeat (40) @(posedge hclk);
		check(32'(scl_w), 32'h0);
		rdc(imtc_pkg::OFF_STAT, imtc_pkg::ST_AW_ACK);
		stretch = 3000;
		for (int k = 0; k < 2; k++)
			send(8'(rnd()), EN, imtc_pkg::ST_D_ACK);
		nack = 1'b1;
		send(8'(rnd()), EN, imtc_pkg::ST_D_NACK);
		nack = 1'b0;
		wr(imtc_pkg::OFF_CTRL, EN | GO);
		wf(imtc_pkg::ST_RESTART);
		send(8'h52, EN, imtc_pkg::ST_AW_NACK);
		wr(imtc_pkg::OFF_CTRL, EN | GO);
		wf(imtc_pkg::ST_RESTART);
		send(SLV, EN, imtc_pkg::ST_AW_ACK);
		stop_wait();
		check(32'(rd[4]), 32'h0);
		rdc(imtc_pkg::OFF_STAT, imtc_pkg::ST_IDLE);
		check(32'({scl_w, sda_w}), 32'h3);
		wr(imtc_pkg::OFF_CTRL, EN | GO);
		wf(imtc_pkg::ST_START);
		send(8'h52, EN, imtc_pkg::ST_AW_NACK);
		wr(imtc_pkg::OFF_CTRL, EN | GO | STP);
		wf(imtc_pkg::ST_START);
		rdc(imtc_pkg::OFF_CTRL, EN | GO | 8'h08);
		send(SLV | 8'h01, EN, imtc_pkg::ST_AR_ACK);
		stop_wait();
		$display("test master done");
		wr(imtc_pkg::OFF_CTRL, EN | GO);
		wf(imtc_pkg::ST_START);
		steal <= 1'b1;
		send(8'hf0, EN, imtc_pkg::ST_ARB);
		rdc(imtc_pkg::OFF_IRQ_ST, 8'h04);
		wr(imtc_pkg::OFF_IRQ_ST, 8'h04);
		wr(imtc_pkg::OFF_CTRL, EN);
		repeat (20) @(posedge hclk);
		check(32'({scl_oe, sda_oe}), 32'h0);
		steal <= 1'b0;
		repeat (20) @(posedge hclk);
		wr(imtc_pkg::OFF_CTRL, EN | GO);
		wf(imtc_pkg::ST_START);
		steal <= 1'b1;
		send(8'hf0, EN, imtc_pkg::ST_ARB);
		wr(imtc_pkg::OFF_IRQ_ST, 8'h04);
		wr(imtc_pkg::OFF_CTRL, EN | GO);
		repeat (60) @(posedge hclk);
		check(32'(sda_oe), 32'h0);
		steal <= 1'b0;
		wf(imtc_pkg::ST_START);
		stop_wait();
		$display("test arbitration done");
		summarize();
	end
endmodule
